// ---- design/rrs_defs.svh ----
// constants of the reset release sequencer
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RRS_CLK_MHZ 100
`define RRS_EXT_CYCLES 16070
`define RRS_HOLD_MIN_US 250
`define RRS_HOLD_MIN_CYCLES (`RRS_HOLD_MIN_US * `RRS_CLK_MHZ)
`define RRS_MEM_DIV 6
`define RRS_CNT_W 16

// ----------------------------------------------------------------------------
// reset values and pin positions
// ----------------------------------------------------------------------------
`define RRS_PIN_RST 0
`define RRS_PIN_ECLK 1
`define RRS_PIN_STRAP0 2
`define RRS_PIN_STRAP1 3
`define RRS_PIN_ESEL 4
`define RRS_NPINS 5
`define RRS_PLL_MULT_RST 2'h0

`endif

// ---- design/rrs_pkg.sv ----
// types of the reset release sequencer
package rrs_pkg;

  typedef enum logic [2:0]
  {
    RRS_ST_HOLD = 3'h1,
    RRS_ST_EXTEND = 3'h2,
    RRS_ST_RUN = 3'h4
  } rrs_state_t;

  typedef struct packed
  {
    logic timer;
    logic serial;
    logic mem_port;
  } rrs_tick_t;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } rrs_sync_t;

  // three-flop synchroniser; the level is taken once stages two and three agree
  function automatic rrs_sync_t rrs_sync_step(input rrs_sync_t cur, input logic pin);
    rrs_sync_t nxt;
    nxt.s1 = pin;
    nxt.s2 = cur.s1;
    nxt.s3 = cur.s2;
    nxt.filt = (cur.s2 == cur.s3) ? cur.s3 : cur.filt;
    return nxt;
  endfunction

endpackage

// ---- design/rrs_clk_div.sv ----
// integer divider producing a one-cycle tick every div cycles
`timescale 1ns/1ns
module rrs_clk_div
  import rrs_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  input wire logic [W-1:0] div,
  // tick
  output logic tick_reg
);

  generate
    if (W < 1 || W > 16)
    begin : g_chk
      $error("rrs_clk_div: W out of range");
    end
  endgenerate

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire [W-1:0] lim = (div <= W'(1)) ? '0 : div - W'(1);
  wire at_lim = (cnt_reg >= lim);

  assign cnt_next = (clear || at_lim) ? '0 : cnt_reg + W'(1);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= !clear && at_lim;
    end
  end

  a_div_tick_limit: assert property (@(posedge mclk) disable iff (sys_rst)
    tick_reg |-> ($past(cnt_reg) >= $past(lim)) && !$past(clear))
    else $error("divider tick without reaching its limit");

  a_div_no_early: assert property (@(posedge mclk) disable iff (sys_rst)
    (!clear && cnt_reg < lim) |=> !tick_reg)
    else $error("divider tick came early");

endmodule

// ---- design/rrs_top.sv ----
// reset release sequencer: core reset extension, PLL reset and peripheral clock ticks
`timescale 1ns/1ns
`include "rrs_defs.svh"
module rrs_top
  import rrs_pkg::*;
#(
  parameter int EXT_CYCLES = `RRS_EXT_CYCLES,
  parameter int HOLD_MIN_CYCLES = `RRS_HOLD_MIN_CYCLES,
  parameter int DIV_W = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // board pins
  input wire logic rst_pin_n,
  input wire logic [1:0] pll_multiplier_select,
  input wire logic mem_port_ext_clock_in,
  input wire logic mem_ext_clk_sel,
  // peripheral divider factor
  input wire logic [DIV_W-1:0] periph_div_sel,
  // reset outputs
  output logic core_rst,
  output logic pll_rst,
  output logic short_reset,
  output logic [1:0] pll_mult,
  // peripheral ticks
  output rrs_tick_t ticks
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  generate
    // the release assertions watch eight cycles of extension
    if (EXT_CYCLES < 8 || EXT_CYCLES > 65535)
    begin : g_chk_ext
      $error("rrs_top: EXT_CYCLES out of range");
    end
    if (HOLD_MIN_CYCLES < 1 || HOLD_MIN_CYCLES > 65535)
    begin : g_chk_hold
      $error("rrs_top: HOLD_MIN_CYCLES out of range");
    end
    if (DIV_W < 3 || DIV_W > 16)
    begin : g_chk_div
      $error("rrs_top: DIV_W out of range");
    end
  endgenerate

  localparam logic [`RRS_CNT_W-1:0] EXT_LAST = `RRS_CNT_W'(EXT_CYCLES - 1);
  localparam logic [`RRS_CNT_W-1:0] HOLD_LAST = `RRS_CNT_W'(HOLD_MIN_CYCLES - 1);
  localparam logic [DIV_W-1:0] MEM_DIV = DIV_W'(`RRS_MEM_DIV);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  rrs_sync_t sync_reg [`RRS_NPINS];
  wire [`RRS_NPINS-1:0] pin_vec;

  assign pin_vec[`RRS_PIN_RST] = rst_pin_n;
  assign pin_vec[`RRS_PIN_ECLK] = mem_port_ext_clock_in;
  assign pin_vec[`RRS_PIN_STRAP0] = pll_multiplier_select[0];
  assign pin_vec[`RRS_PIN_STRAP1] = pll_multiplier_select[1];
  assign pin_vec[`RRS_PIN_ESEL] = mem_ext_clk_sel;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `RRS_NPINS; i++)
      begin
        sync_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < `RRS_NPINS; i++)
      begin
        sync_reg[i] <= rrs_sync_step(sync_reg[i], pin_vec[i]);
      end
    end
  end

  // filtered levels; the reset pin reads as asserted until it is seen high
  wire rst_act = !sync_reg[`RRS_PIN_RST].filt;
  wire eclk_lvl = sync_reg[`RRS_PIN_ECLK].filt;
  wire ext_sel = sync_reg[`RRS_PIN_ESEL].filt;
  wire [1:0] strap_now = {sync_reg[`RRS_PIN_STRAP1].filt, sync_reg[`RRS_PIN_STRAP0].filt};

  // --------------------------------------------------------------------------
  // reset sequencer
  // --------------------------------------------------------------------------
  rrs_state_t state_reg;
  rrs_state_t state_next;
  logic [`RRS_CNT_W-1:0] ext_cnt_reg;
  logic [`RRS_CNT_W-1:0] ext_cnt_next;
  logic [`RRS_CNT_W-1:0] hold_cnt_reg;
  logic [`RRS_CNT_W-1:0] hold_cnt_next;
  logic short_next;
  logic [1:0] pll_mult_next;
  logic core_rst_next;
  logic pll_rst_next;

  wire in_hold = (state_reg == RRS_ST_HOLD);
  wire in_ext = (state_reg == RRS_ST_EXTEND);
  wire ext_done = (ext_cnt_reg == EXT_LAST);
  wire hold_full = (hold_cnt_reg >= HOLD_LAST);
  wire releasing = in_hold && !rst_act;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RRS_ST_HOLD:
        if (!rst_act)
          state_next = RRS_ST_EXTEND;
      RRS_ST_EXTEND:
        if (rst_act)
          state_next = RRS_ST_HOLD;
        else if (ext_done)
          state_next = RRS_ST_RUN;
      RRS_ST_RUN:
        if (rst_act)
          state_next = RRS_ST_HOLD;
      default:
        state_next = RRS_ST_HOLD;
    endcase
  end

  // extension counter restarts from zero on any new reset
  assign ext_cnt_next = (in_ext && !rst_act) ? ext_cnt_reg + `RRS_CNT_W'(1) : '0;
  assign hold_cnt_next = !in_hold ? '0 :
    (hold_full ? hold_cnt_reg : hold_cnt_reg + `RRS_CNT_W'(1));
  // a pulse too short for the PLL to settle is flagged at release
  assign short_next = releasing ? !hold_full : short_reset;
  assign pll_mult_next = releasing ? strap_now : pll_mult;
  assign core_rst_next = (state_next != RRS_ST_RUN);
  assign pll_rst_next = (state_next == RRS_ST_HOLD);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= RRS_ST_HOLD;
      ext_cnt_reg <= '0;
      hold_cnt_reg <= '0;
      short_reset <= 1'b0;
      pll_mult <= `RRS_PLL_MULT_RST;
      core_rst <= 1'b1;
      pll_rst <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      ext_cnt_reg <= ext_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      short_reset <= short_next;
      pll_mult <= pll_mult_next;
      core_rst <= core_rst_next;
      pll_rst <= pll_rst_next;
    end
  end

  // --------------------------------------------------------------------------
  // peripheral clock ticks
  // --------------------------------------------------------------------------
  logic periph_tick;
  logic mem_div_tick;
  logic eclk_prev_reg;
  rrs_tick_t ticks_next;

  rrs_clk_div #(.W(DIV_W)) u_periph_div
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(core_rst),
    .div(periph_div_sel),
    .tick_reg(periph_tick)
  );

  rrs_clk_div #(.W(DIV_W)) u_mem_div
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(core_rst),
    .div(MEM_DIV),
    .tick_reg(mem_div_tick)
  );

  wire eclk_rise = eclk_lvl && !eclk_prev_reg;

  assign ticks_next.timer = !core_rst && periph_tick;
  assign ticks_next.serial = !core_rst && periph_tick;
  // external memory clock takes over whenever selected, whatever the CPU rate
  assign ticks_next.mem_port = !core_rst && (ext_sel ? eclk_rise : mem_div_tick);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      eclk_prev_reg <= 1'b0;
      ticks <= '0;
    end
    else
    begin
      eclk_prev_reg <= eclk_lvl;
      ticks <= ticks_next;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence s_mem_gap;
    !mem_div_tick [*5] ##1 mem_div_tick;
  endsequence

  sequence s_release;
    in_hold && !rst_act;
  endsequence

  a_core_held_ext: assert property (@(posedge mclk) disable iff (sys_rst)
    s_release |=> core_rst [*8])
    else $error("core reset dropped right after pin release");

  a_core_after_count: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(core_rst) |-> $past(ext_cnt_reg) == EXT_LAST && $past(in_ext, 2))
    else $error("core reset released before the extension count");

  a_core_during_pin: assert property (@(posedge mclk) disable iff (sys_rst)
    rst_act |=> core_rst && pll_rst)
    else $error("core or pll reset low while pin asserted");

  a_pll_on_reset: assert property (@(posedge mclk) disable iff (sys_rst)
    ($rose(rst_act) && !in_hold) |=> pll_rst && $rose(pll_rst))
    else $error("pll not reset on pin assertion");

  a_pll_free_run: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == RRS_ST_RUN) |-> !pll_rst)
    else $error("pll reset asserted while running");

  a_ext_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (in_ext && rst_act) |=> in_hold && ext_cnt_reg == '0)
    else $error("extension count not abandoned on new reset");

  a_mem_div_six: assert property (@(posedge mclk) disable iff (sys_rst || core_rst)
    mem_div_tick |=> s_mem_gap)
    else $error("memory port tick spacing is not six cycles");

  a_mem_tick_src: assert property (@(posedge mclk) disable iff (sys_rst)
    (!core_rst && !ext_sel && !mem_div_tick) |=> !ticks.mem_port)
    else $error("memory tick without internal divider in internal mode");

  a_short_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    s_release |=> short_reset == !$past(hold_full))
    else $error("short reset flag wrong at release");

endmodule

// ---- tb/rrs_board_model.sv ----
// board-side reset driver, strap pins and external memory port clock
`timescale 1ns/1ns
module rrs_board_model
(
  // clock
  input wire logic mclk,
  // board pins
  output logic rst_pin_n,
  output logic [1:0] pll_multiplier_select,
  output logic mem_port_ext_clock_in
);
  initial
  begin
    rst_pin_n = 1'b0;
    pll_multiplier_select = 2'h3;
    mem_port_ext_clock_in = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // reset pulse: pin low for n cycles with the given straps, then released
  // ---------------------------------------------------------------------------
  task automatic pulse(input int n, input logic [1:0] strap);
    @(negedge mclk);
    rst_pin_n = 1'b0;
    pll_multiplier_select = strap;
    repeat (n) @(negedge mclk);
    rst_pin_n = 1'b1;
  endtask

  // ---------------------------------------------------------------------------
  // memory port clock: toggles every half cycles, well below mclk/4
  // ---------------------------------------------------------------------------
  task automatic ext_clock(input int edges, input int half);
    repeat (edges)
    begin
      repeat (half) @(negedge mclk);
      mem_port_ext_clock_in = ~mem_port_ext_clock_in;
    end
  endtask
endmodule

// ---- tb/reset_release_sequencer_tb.sv ----
// self-checking bench of the reset release sequencer
`timescale 1ns/1ns
module reset_release_sequencer_tb;
  import rrs_pkg::*;
  localparam int EXT = 20;
  localparam int HOLD = 10;
  logic mclk;
  logic sys_rst;
  logic rst_pin_n;
  logic [1:0] strap_pins;
  logic ext_clk;
  logic mem_ext_clk_sel;
  logic [7:0] periph_div_sel;
  logic core_rst;
  logic pll_rst;
  logic short_reset;
  logic [1:0] pll_mult;
  rrs_tick_t ticks;
  int err_total;
  int cmp_count;
  int cyc;
  logic [31:0] seed;

  rrs_top #(.EXT_CYCLES(EXT), .HOLD_MIN_CYCLES(HOLD), .DIV_W(8)) u_dut
  (
    .mclk(mclk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
    .pll_multiplier_select(strap_pins), .mem_port_ext_clock_in(ext_clk),
    .mem_ext_clk_sel(mem_ext_clk_sel), .periph_div_sel(periph_div_sel),
    .core_rst(core_rst), .pll_rst(pll_rst), .short_reset(short_reset),
    .pll_mult(pll_mult), .ticks(ticks)
  );

  rrs_board_model u_board
  (
    .mclk(mclk), .rst_pin_n(rst_pin_n), .pll_multiplier_select(strap_pins),
    .mem_port_ext_clock_in(ext_clk)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t mismatch seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // tick spacing for a divide factor; 0 and 1 tick every cycle
  function automatic int exp_gap(input logic [7:0] d);
    return (d <= 8'h01) ? 1 : int'(d);
  endfunction

  // cycles from pin release until the core reset falls
  task automatic ext_len(output int n);
    n = 0;
    while (core_rst !== 1'b0 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  // spacing of two successive pulses on one tick line
  task automatic tick_gap(input int idx, output int n);
    int k;
    k = 0;
    while (ticks[idx] !== 1'b1 && k < 100)
    begin
      @(negedge mclk);
      k++;
    end
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (ticks[idx] !== 1'b1 && n < 100);
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    int n;
    logic [31:0] r;
    sys_rst = 1'b1;
    mem_ext_clk_sel = 1'b0;
    periph_div_sel = 8'h06;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    seed = 32'h0000_002f;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      // last pass: divide factor 0 or 1, picked by r[0], as a corner case
      periph_div_sel = (i == 3) ? {7'h00, r[0]} : 8'h02 + {5'h00, r[10:8]};
      u_board.pulse(HOLD + 5 + i, r[1:0]);
      check(pll_rst, 1'b1);
      check(ticks, 3'h0);
      ext_len(n);
      check(n >= EXT && n <= EXT + 6, 1'b1);
      check(pll_rst, 1'b0);
      check(pll_mult, r[1:0]);
      check(short_reset, 1'b0);
      tick_gap(0, n);
      check(n, 6);
      tick_gap(2, n);
      check(n, exp_gap(periph_div_sel));
      tick_gap(1, n);
      check(n, exp_gap(periph_div_sel));
    end
    $display("test release_and_ticks done");
    u_board.pulse(HOLD + 5, 2'h3);
    repeat (10) @(negedge mclk);
    u_board.pulse(5, 2'h1);
    ext_len(n);
    check(n >= EXT && n <= EXT + 6, 1'b1);
    check(short_reset, 1'b1);
    check(pll_mult, 2'h1);
    $display("test restart_in_extension done");
    mem_ext_clk_sel = 1'b1;
    repeat (8) @(negedge mclk);
    fork
      u_board.ext_clock(16, 5);
      begin
        tick_gap(0, n);
        check(n, 10);
      end
    join
    $display("test external_mem_clock done");
    give_verdict();
  end
endmodule
